// ==== include/cts_pkg.sv ====
// constants, codes, states and sequence arithmetic of the control transport session
// assumes one 20 MHz clock shared by the session logic and the packet link
package cts_pkg;

  // ==========================================================================
  // header field layout and control codes
  localparam int             SEQ_W              = 10;
  localparam int             CODE_W             = 2;
  localparam int             REP_W              = 4;
  localparam logic [9:0]     SEQ_MAX            = 10'h3e7;  // 999, numbering wraps to 000
  localparam logic [9:0]     SEQ_MOD            = 10'h3e8;  // 1000
  localparam logic [9:0]     INIT_SEQ           = 10'h000;  // any start number is legal
  localparam logic [1:0]     NO_CONTROL_CODE    = 2'h0;
  localparam logic [1:0]     OPEN_REQUEST_CODE  = 2'h1;
  localparam logic [1:0]     CLOSE_REQUEST_CODE = 2'h2;
  localparam logic [3:0]     RESEND_COUNT_ZERO  = 4'h0;

  // ==========================================================================
  // timing
  localparam int             CLK_KHZ            = 20000;
  localparam int             ACK_TIMEOUT_US     = 1000;
  localparam int             ACK_TIMEOUT_CYC    = (ACK_TIMEOUT_US * CLK_KHZ) / 1000;

  // ==========================================================================
  // session states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPEN_WAIT,
    ST_ACCEPT_WAIT,
    ST_OPEN,
    ST_CLOSE_WAIT,
    ST_FIN_WAIT
  } state_t;

  // next number in the three-digit decimal sequence
  function automatic logic [9:0] seq_inc(input logic [9:0] s);
    seq_inc = (s == SEQ_MAX) ? 10'h000 : 10'(s + 10'h001);
  endfunction : seq_inc

  // forward distance from a to b modulo 1000
  function automatic logic [9:0] seq_dist(input logic [9:0] a, input logic [9:0] b);
    seq_dist = (b >= a) ? 10'(b - a) : 10'(b + SEQ_MOD - a);
  endfunction : seq_dist

endpackage : cts_pkg

// ==== include/timer_if.sv ====
// carrier between the session engine and its acknowledgement timer
// assumes both ends run on the same clock
interface timer_if;
  logic run;      // count while something awaits acknowledgement
  logic kick;     // restart the count on progress
  logic expired;  // one-cycle pulse at time-out

  modport ctl (output run, output kick, input expired);
  modport tmr (input run, input kick, output expired);
endinterface : timer_if

// ==== core/ack_timer.sv ====
// acknowledgement time-out counter
// assumes rst_n is already synchronised to clk
module ack_timer #(
  parameter int CYC = cts_pkg::ACK_TIMEOUT_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  timer_if.tmr      t
);

  localparam int CW = $clog2(CYC + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          exp_q, exp_d;

  // ==========================================================================
  // count up while running, restart on kick or after firing
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (t.kick || !t.run) begin
      cnt_d = '0;
    end else if (cnt_q == CW'(CYC - 1)) begin
      cnt_d = '0;
      exp_d = 1'b1;
    end else begin
      cnt_d = CW'(cnt_q + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign t.expired = exp_q;

endmodule : ack_timer

// ==== core/control_transport_session.sv ====
// transport session engine for one end of the control channel
// assumes the packet link and the user side run on REF_CLK; no input but RST_N needs synchronising
// Notes on behaviour
// - open request: open code, ack invalid, no data
// - accept open: open code, ack valid, no data
// - requester acks acceptance plainly; then open
// - either end may start a close
// - close request consumes a sequence number
// - close acceptance also consumes a sequence number
// - initiator acks close acceptance; then closed
// - pending data declines close; close retried later
// - ordinary packets only while connection open
// - every received data packet gets acknowledged
// - own data may ride on acknowledgements
// - receipt number is next expected number
// - resend count field always sent zero
// - numbers detect loss, drive retransmission
// - out-of-order packets are discarded
// - time-out rewinds; duplicates are discarded
module control_transport_session #(
  parameter int DATA_W      = 8,
  parameter int DEPTH       = 8,  // must divide 1000 and be a power of two
  parameter int TIMEOUT_CYC = cts_pkg::ACK_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                        REF_CLK,
  input  wire logic                        RST_N,
  // session control and status
  input  wire logic                        OPEN_REQ,
  input  wire logic                        CLOSE_REQ,
  output logic                             LINK_OPEN,
  // outgoing transport packets
  output logic                             TX_VALID,
  input  wire logic                        TX_READY,
  output logic [cts_pkg::SEQ_W-1:0]        TX_SEQ,
  output logic [cts_pkg::SEQ_W-1:0]        TX_ACK,
  output logic                             TX_ACK_OK,
  output logic [cts_pkg::CODE_W-1:0]       TX_CODE,
  output logic [cts_pkg::REP_W-1:0]        TX_REP,
  output logic                             TX_HAS_DATA,
  output logic [DATA_W-1:0]                TX_DATA,
  // incoming transport packets
  input  wire logic                        RX_VALID,
  input  wire logic [cts_pkg::SEQ_W-1:0]   RX_SEQ,
  input  wire logic [cts_pkg::SEQ_W-1:0]   RX_ACK,
  input  wire logic                        RX_ACK_OK,
  input  wire logic [cts_pkg::CODE_W-1:0]  RX_CODE,
  input  wire logic                        RX_HAS_DATA,
  input  wire logic [DATA_W-1:0]           RX_DATA,
  // user logical packets
  input  wire logic                        SEND_VALID,
  input  wire logic [DATA_W-1:0]           SEND_DATA,
  output logic                             SEND_READY,
  output logic                             RECV_VALID,
  output logic [DATA_W-1:0]                RECV_DATA
);

  localparam int AW = $clog2(DEPTH);
  typedef logic [cts_pkg::SEQ_W-1:0] seq_t;

  // ==========================================================================
  // reset release
  logic rs1_q, rs2_q, rst_n;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_n = rs2_q;

  // ==========================================================================
  // time-out timer
  timer_if tif ();
  ack_timer #(.CYC(TIMEOUT_CYC)) u_timer (.clk(REF_CLK), .rst_n(rst_n), .t(tif));

  // ==========================================================================
  // state
  cts_pkg::state_t     st_q, st_d;
  seq_t                top_q, top_d;     // next new sequence number
  seq_t                base_q, base_d;   // oldest unacknowledged number
  seq_t                snd_q, snd_d;     // next number to put on the wire
  seq_t                exp_q, exp_d;     // next number expected from the peer
  logic [1:0]          hs_code_q, hs_code_d;
  seq_t                hs_seq_q, hs_seq_d;
  logic                hs_ok_q, hs_ok_d;
  logic                ack_pend_q, ack_pend_d;
  logic                txv_q, txv_d, txok_q, txok_d, txdat_q, txdat_d;
  seq_t                txs_q, txs_d, txa_q, txa_d;
  logic [1:0]          txc_q, txc_d;
  logic [DATA_W-1:0]   txp_q, txp_d;
  logic                rdy_q, rdy_d, open_q, open_d, rv_q, rv_d;
  logic [DATA_W-1:0]   rd_q, rd_d;
  logic [DATA_W-1:0]   buf_mem [DEPTH];  // unacknowledged payloads by slot
  logic                take, launch;

  // ==========================================================================
  // next-state computation
  always_comb begin
    st_d = st_q;  top_d = top_q;  base_d = base_q;  snd_d = snd_q;  exp_d = exp_q;
    hs_code_d = hs_code_q;  hs_seq_d = hs_seq_q;  hs_ok_d = hs_ok_q;  ack_pend_d = ack_pend_q;
    txs_d = txs_q;  txa_d = txa_q;  txok_d = txok_q;  txc_d = txc_q;  txdat_d = txdat_q;  txp_d = txp_q;
    rv_d = 1'b0;  rd_d = rd_q;  launch = 1'b0;
    txv_d = txv_q & ~TX_READY;
    // new user data first: it was promised a slot by SEND_READY
    take = rdy_q & SEND_VALID;
    if (take) begin
      launch = 1'b1;
      txs_d = top_q;  txc_d = cts_pkg::NO_CONTROL_CODE;  txok_d = 1'b1;
      txdat_d = 1'b1;  txp_d = SEND_DATA;
      top_d = cts_pkg::seq_inc(top_q);
      snd_d = top_d;
    end
    // received packet
    if (RX_VALID) begin
      unique case (st_q)
        cts_pkg::ST_IDLE: begin
          if (RX_CODE == cts_pkg::OPEN_REQUEST_CODE) begin
            exp_d = cts_pkg::seq_inc(RX_SEQ);
            hs_code_d = cts_pkg::OPEN_REQUEST_CODE;  hs_ok_d = 1'b1;
            hs_seq_d = top_q;  top_d = cts_pkg::seq_inc(top_q);
            base_d = top_q;  snd_d = top_d;
            st_d = cts_pkg::ST_ACCEPT_WAIT;
          end
        end
        cts_pkg::ST_OPEN_WAIT: begin
          if (RX_CODE == cts_pkg::OPEN_REQUEST_CODE && RX_ACK_OK && RX_ACK == top_q) begin
            exp_d = cts_pkg::seq_inc(RX_SEQ);
            base_d = RX_ACK;
            ack_pend_d = 1'b1;
            st_d = cts_pkg::ST_OPEN;
          end
        end
        cts_pkg::ST_ACCEPT_WAIT, cts_pkg::ST_FIN_WAIT: begin
          if (RX_CODE == cts_pkg::NO_CONTROL_CODE && RX_ACK_OK && RX_ACK == top_q) begin
            base_d = RX_ACK;
            st_d = (st_q == cts_pkg::ST_FIN_WAIT) ? cts_pkg::ST_IDLE : cts_pkg::ST_OPEN;
          end
        end
        cts_pkg::ST_OPEN, cts_pkg::ST_CLOSE_WAIT: begin
          // any receipt inside the outstanding window frees buffer slots
          if (RX_ACK_OK && cts_pkg::seq_dist(base_q, RX_ACK) <= cts_pkg::seq_dist(base_q, top_q))
            base_d = RX_ACK;
          if (RX_HAS_DATA) begin
            ack_pend_d = 1'b1;
            if (RX_SEQ == exp_q) begin
              exp_d = cts_pkg::seq_inc(exp_q);
              rv_d = 1'b1;
              rd_d = RX_DATA;
            end  // else gap or duplicate: dropped, re-ack asks for it again
            if (st_q == cts_pkg::ST_CLOSE_WAIT && RX_CODE == cts_pkg::NO_CONTROL_CODE)
              st_d = cts_pkg::ST_OPEN;
          end
          if (RX_CODE == cts_pkg::CLOSE_REQUEST_CODE && RX_SEQ == exp_q) begin
            exp_d = cts_pkg::seq_inc(exp_q);
            if (st_q == cts_pkg::ST_CLOSE_WAIT) begin
              ack_pend_d = 1'b1;
              st_d = cts_pkg::ST_IDLE;
            end else if (top_d != base_d || SEND_VALID) begin
              ack_pend_d = 1'b1;
            end else begin
              hs_code_d = cts_pkg::CLOSE_REQUEST_CODE;  hs_ok_d = 1'b1;
              hs_seq_d = top_d;  top_d = cts_pkg::seq_inc(top_d);  snd_d = top_d;
              st_d = cts_pkg::ST_FIN_WAIT;
            end
          end
        end
        default: st_d = cts_pkg::ST_IDLE;
      endcase
    end
    // locally started open or close; waits for a quiet cycle
    if (!RX_VALID && !take && hs_code_q == cts_pkg::NO_CONTROL_CODE) begin
      if (st_q == cts_pkg::ST_IDLE && OPEN_REQ && !ack_pend_q) begin
        hs_code_d = cts_pkg::OPEN_REQUEST_CODE;  hs_ok_d = 1'b0;
        hs_seq_d = top_q;  top_d = cts_pkg::seq_inc(top_q);  base_d = top_q;  snd_d = top_d;
        st_d = cts_pkg::ST_OPEN_WAIT;
      end else if (st_q == cts_pkg::ST_OPEN && CLOSE_REQ && base_q == top_q && !ack_pend_q) begin
        hs_code_d = cts_pkg::CLOSE_REQUEST_CODE;  hs_ok_d = 1'b1;
        hs_seq_d = top_q;  top_d = cts_pkg::seq_inc(top_q);  snd_d = top_d;
        st_d = cts_pkg::ST_CLOSE_WAIT;
      end
    end
    // time-out: go back to the oldest open number, or drop a stalled handshake
    if (tif.expired) begin
      if (st_q == cts_pkg::ST_OPEN) snd_d = base_d;
      else st_d = cts_pkg::ST_IDLE;
    end
    // other transmissions when the slot is free
    if (!txv_q && !take) begin
      if (hs_code_q != cts_pkg::NO_CONTROL_CODE) begin
        launch = 1'b1;
        txs_d = hs_seq_q;  txc_d = hs_code_q;  txok_d = hs_ok_q;  txdat_d = 1'b0;
        hs_code_d = cts_pkg::NO_CONTROL_CODE;
      end else if (st_q == cts_pkg::ST_OPEN && snd_q != top_q && !tif.expired) begin
        launch = 1'b1;  // retransmission from the buffer
        txs_d = snd_q;  txc_d = cts_pkg::NO_CONTROL_CODE;  txok_d = 1'b1;
        txdat_d = 1'b1;  txp_d = buf_mem[snd_q[AW-1:0]];
        snd_d = cts_pkg::seq_inc(snd_q);
      end else if (ack_pend_q) begin
        launch = 1'b1;  // plain receipt
        txs_d = top_q;  txc_d = cts_pkg::NO_CONTROL_CODE;  txok_d = 1'b1;  txdat_d = 1'b0;
      end
    end
    if (launch) begin
      txv_d = 1'b1;
      txa_d = exp_d;
      if (txc_d != cts_pkg::OPEN_REQUEST_CODE || txok_d)
        ack_pend_d = RX_VALID & RX_HAS_DATA & ~take & (hs_code_q != cts_pkg::NO_CONTROL_CODE);
    end
    rdy_d = (st_d == cts_pkg::ST_OPEN) && !txv_d && hs_code_d == cts_pkg::NO_CONTROL_CODE
            && snd_d == top_d && cts_pkg::seq_dist(base_d, top_d) < seq_t'(DEPTH);
    open_d = (st_d == cts_pkg::ST_OPEN);
  end

  // timer runs while a handshake or data awaits receipt
  assign tif.run  = (st_q != cts_pkg::ST_IDLE) && (st_q != cts_pkg::ST_OPEN || base_q != top_q);
  assign tif.kick = (st_d != st_q) || (base_d != base_q) || (snd_d != snd_q && !take && !launch);

  // ==========================================================================
  // registers
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cts_pkg::ST_IDLE;
      top_q <= cts_pkg::INIT_SEQ;  base_q <= cts_pkg::INIT_SEQ;
      snd_q <= cts_pkg::INIT_SEQ;  exp_q <= cts_pkg::INIT_SEQ;
      hs_code_q <= cts_pkg::NO_CONTROL_CODE;  hs_seq_q <= cts_pkg::INIT_SEQ;  hs_ok_q <= 1'b0;
      ack_pend_q <= 1'b0;  txv_q <= 1'b0;  txok_q <= 1'b0;  txdat_q <= 1'b0;
      txs_q <= cts_pkg::INIT_SEQ;  txa_q <= cts_pkg::INIT_SEQ;
      txc_q <= cts_pkg::NO_CONTROL_CODE;  txp_q <= '0;
      rdy_q <= 1'b0;  open_q <= 1'b0;  rv_q <= 1'b0;  rd_q <= '0;
    end else begin
      st_q <= st_d;
      top_q <= top_d;  base_q <= base_d;  snd_q <= snd_d;  exp_q <= exp_d;
      hs_code_q <= hs_code_d;  hs_seq_q <= hs_seq_d;  hs_ok_q <= hs_ok_d;
      ack_pend_q <= ack_pend_d;  txv_q <= txv_d;  txok_q <= txok_d;  txdat_q <= txdat_d;
      txs_q <= txs_d;  txa_q <= txa_d;  txc_q <= txc_d;  txp_q <= txp_d;
      rdy_q <= rdy_d;  open_q <= open_d;  rv_q <= rv_d;  rd_q <= rd_d;
    end
  end

  // payload store; a slot is reused only after its number is acknowledged
  always_ff @(posedge REF_CLK) begin
    if (take) buf_mem[top_q[AW-1:0]] <= SEND_DATA;
  end

  // ==========================================================================
  // outputs
  assign TX_VALID    = txv_q;
  assign TX_SEQ      = txs_q;
  assign TX_ACK      = txa_q;
  assign TX_ACK_OK   = txok_q;
  assign TX_CODE     = txc_q;
  assign TX_REP      = cts_pkg::RESEND_COUNT_ZERO;
  assign TX_HAS_DATA = txdat_q;
  assign TX_DATA     = txp_q;
  assign SEND_READY  = rdy_q;
  assign RECV_VALID  = rv_q;
  assign RECV_DATA   = rd_q;
  assign LINK_OPEN   = open_q;

endmodule : control_transport_session

// ==== testbench/cts_assertions.sv ====
// concurrent checks on the session engine, seeing only its ports
// assumes the bind at the foot reaches every engine instance
module cts_checker #(parameter int DATA_W = 8) (
  // clock, reset and session control
  input wire logic              REF_CLK, RST_N, OPEN_REQ, CLOSE_REQ, LINK_OPEN,
  // outgoing packets
  input wire logic              TX_VALID, TX_READY, TX_ACK_OK, TX_HAS_DATA,
  input wire logic [9:0]        TX_SEQ, TX_ACK,
  input wire logic [1:0]        TX_CODE,
  input wire logic [3:0]        TX_REP,
  // incoming packets and user words
  input wire logic              RX_VALID, RX_ACK_OK, RX_HAS_DATA, SEND_VALID, SEND_READY, RECV_VALID,
  input wire logic [9:0]        RX_SEQ, RX_ACK,
  input wire logic [1:0]        RX_CODE,
  input wire logic [DATA_W-1:0] TX_DATA, RX_DATA, SEND_DATA, RECV_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  // ==================================================================
  // open handshake steps
  sequence s_req_taken;
    TX_VALID && TX_READY && TX_CODE == 2'h1 && !TX_ACK_OK;
  endsequence
  sequence s_accept_rx;
    RX_VALID && RX_CODE == 2'h1 && RX_ACK_OK;
  endsequence
  // ==================================================================
  // field and timing relations
  a_open_done: assert property (s_req_taken ##[1:20] s_accept_rx |=> LINK_OPEN)
    else $error("link not open after acceptance");
  a_rep_zero: assert property (TX_VALID |-> TX_REP == 4'h0) else $error("resend count not zero");
  a_req_fields: assert property (TX_VALID && !TX_ACK_OK |-> TX_CODE == 2'h1 && !TX_HAS_DATA)
    else $error("bad open request fields");
  a_coded_empty: assert property (TX_VALID && TX_CODE != 2'h0 |-> !TX_HAS_DATA)
    else $error("coded packet carries data");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable({TX_SEQ, TX_ACK, TX_CODE, TX_DATA}))
    else $error("packet changed before taken");
  a_tx_gap: assert property (TX_VALID && TX_READY |=> !TX_VALID) else $error("no idle cycle after packet");
  a_send_open: assert property (SEND_VALID && SEND_READY |-> LINK_OPEN) else $error("word taken while closed");
  a_send_launch: assert property (SEND_VALID && SEND_READY |=> TX_VALID && TX_HAS_DATA && TX_DATA == $past(SEND_DATA))
    else $error("taken word not launched");
  a_recv_src: assert property (RECV_VALID |-> $past(RX_VALID) && $past(RX_HAS_DATA) && RECV_DATA == $past(RX_DATA))
    else $error("delivered word has no source");
endmodule : cts_checker

bind control_transport_session cts_checker #(.DATA_W(DATA_W)) u_chk (
  .REF_CLK, .RST_N, .OPEN_REQ, .CLOSE_REQ, .LINK_OPEN, .TX_VALID, .TX_READY, .TX_ACK_OK, .TX_HAS_DATA, .TX_SEQ,
  .TX_ACK, .TX_CODE, .TX_REP, .RX_VALID, .RX_ACK_OK, .RX_HAS_DATA, .SEND_VALID, .SEND_READY, .RECV_VALID,
  .RX_SEQ, .RX_ACK, .RX_CODE, .TX_DATA, .RX_DATA, .SEND_DATA, .RECV_DATA);

// ==== testbench/cts_peer_model.sv ====
// far-end transport entity answering the session engine
// assumes a packet is taken at an edge with valid and ready both high
module cts_peer_model #(parameter int DATA_W = 8, parameter logic [9:0] START_SEQ = 10'h1c8) (
  // clock and reset
  input wire logic          clk, rst_n,
  // engine packets and bench commands
  input wire logic          tx_valid, tx_ready, tx_ack_ok, tx_has_data, piggy, close_cmd,
  input wire logic [9:0]    tx_seq, tx_ack,
  input wire logic [1:0]    tx_code,
  // packets to the engine
  output logic              rx_valid, rx_ack_ok, rx_has_data, acked_all,
  output logic [9:0]        rx_seq, rx_ack,
  output logic [1:0]        rx_code,
  output logic [DATA_W-1:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] ps, nx;  // own next number, number expected next
  logic [7:0] pc;      // own words sent, doubles as payload
  logic       cl;      // a close began here
  logic       cq;      // close ordered but not yet sent; a take on the same edge must not lose it
  function automatic logic [9:0] inc(input logic [9:0] s);
    return (s == 10'h3e7) ? 10'h000 : 10'(s + 10'h001);
  endfunction : inc
  initial {rx_valid, rx_ack_ok, rx_has_data, acked_all, rx_seq, rx_ack, rx_code, rx_data} = '0;
  // ==================================================================
  // replies; idle seq, ack and data fields flip each cycle so stale values never look fresh
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rx_valid, cl, cq, pc, nx} <= '0;
      ps <= START_SEQ;
    end else begin
      rx_valid <= 1'b0;
      cq       <= cq | close_cmd;
      {rx_seq, rx_ack, rx_data} <= ~{rx_seq, rx_ack, rx_data};
      if (tx_valid && tx_ready) begin
        acked_all <= tx_ack_ok && tx_ack == ps;
        {rx_seq, rx_ack, rx_ack_ok, rx_has_data, rx_code} <= {ps, inc(tx_seq), 2'b10, 2'h0};
        if (tx_code != 2'h0 || tx_has_data) nx <= inc(tx_seq);
        if (tx_code == 2'h1 || (tx_code == 2'h2 && !cl)) begin
          {rx_valid, rx_code} <= {1'b1, tx_code};
          ps <= inc(ps);
        end else if (tx_code == 2'h2) begin
          {rx_valid, cl} <= 2'b10;
        end else if (tx_has_data) begin
          rx_valid    <= 1'b1;
          rx_code     <= cl ? 2'h2 : 2'h0;
          rx_has_data <= piggy && !cl;
          rx_data     <= DATA_W'(pc ^ 8'h5a);
          if (piggy || cl) ps <= inc(ps);
          if (piggy && !cl) pc <= pc + 8'h01;
        end
      end else if (close_cmd || cq) begin
        {rx_valid, rx_seq, rx_ack, rx_ack_ok, rx_has_data, rx_code} <= {1'b1, ps, nx, 2'b10, 2'h2};
        ps <= inc(ps);
        cl <= 1'b1;
        cq <= 1'b0;
      end
    end
  end
endmodule : cts_peer_model

// ==== testbench/control_transport_session_tb_top.sv ====
// self-checking bench: engine against a far-end model, random words and stalls
// assumes the checker binds itself from its own file
module control_transport_session_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // signals, clock and instances
  logic       REF_CLK = 1'b0, RST_N = 1'b0, OPEN_REQ = 1'b0, CLOSE_REQ = 1'b0, TX_READY = 1'b0;
  logic       SEND_VALID = 1'b0, piggy = 1'b0, close_cmd = 1'b0, LINK_OPEN, TX_VALID, TX_ACK_OK;
  logic       TX_HAS_DATA, RX_VALID, RX_ACK_OK, RX_HAS_DATA, SEND_READY, RECV_VALID, acked_all;
  logic [7:0] SEND_DATA = 8'h00, rcnt = 8'h00, TX_DATA, RX_DATA, RECV_DATA;
  logic [9:0] exp_seq = 10'h000, TX_SEQ, TX_ACK, RX_SEQ, RX_ACK;
  logic [1:0] TX_CODE, RX_CODE;
  logic [3:0] TX_REP;
  logic [7:0] sent_q[$];
  int         seed = 62, bad_count = 0, cmp_count = 0, cyc = 0;
  always #25 REF_CLK = ~REF_CLK;
  control_transport_session #(.DATA_W(8), .DEPTH(8), .TIMEOUT_CYC(50)) u_dut (
    .REF_CLK, .RST_N, .OPEN_REQ, .CLOSE_REQ, .LINK_OPEN, .TX_VALID, .TX_READY, .TX_SEQ, .TX_ACK, .TX_ACK_OK,
    .TX_CODE, .TX_REP, .TX_HAS_DATA, .TX_DATA, .RX_VALID, .RX_SEQ, .RX_ACK, .RX_ACK_OK, .RX_CODE,
    .RX_HAS_DATA, .RX_DATA, .SEND_VALID, .SEND_DATA, .SEND_READY, .RECV_VALID, .RECV_DATA);
  cts_peer_model #(.DATA_W(8)) u_peer (
    .clk(REF_CLK), .rst_n(RST_N), .tx_valid(TX_VALID), .tx_ready(TX_READY), .tx_ack_ok(TX_ACK_OK),
    .tx_has_data(TX_HAS_DATA), .piggy, .close_cmd, .tx_seq(TX_SEQ), .tx_ack(TX_ACK), .tx_code(TX_CODE),
    .rx_valid(RX_VALID), .rx_ack_ok(RX_ACK_OK), .rx_has_data(RX_HAS_DATA), .acked_all, .rx_seq(RX_SEQ),
    .rx_ack(RX_ACK), .rx_code(RX_CODE), .rx_data(RX_DATA));
  // ==================================================================
  // helpers
  function automatic logic [9:0] nxt(input logic [9:0] s);
    return (s == 10'h3e7) ? 10'h000 : 10'(s + 10'h001);
  endfunction : nxt
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({9'h000, got}, {9'h000, exp});
  endtask : chk_bit
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // bounded wait, since a lost handshake would otherwise hang here
  task automatic wait_link(input logic lvl);
    for (int n = 0; n < 3000 && LINK_OPEN !== lvl; n++) @(posedge REF_CLK);
    chk_bit(LINK_OPEN, lvl);
  endtask : wait_link
  // the link drops at the close request; let the handshake finish, then nothing may be sent
  task automatic settle();
    repeat (100) @(posedge REF_CLK);
    chk_bit(TX_VALID, 1'b0);
  endtask : settle
  // valid stays up between words; the caller lowers it
  task automatic send_word(input logic [7:0] d);
    {SEND_VALID, SEND_DATA} <= {1'b1, d};
    do @(posedge REF_CLK); while (SEND_READY !== 1'b1);
    sent_q.push_back(d);
  endtask : send_word
  // ==================================================================
  // random stalls, hang limit and packet monitor
  always @(posedge REF_CLK) begin
    TX_READY <= ($random(seed) % 4) != 0;
    piggy    <= ($random(seed) % 2) != 0;
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      close_out();
    end
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
      chk_val(10'(TX_REP), 10'h000);
      if (TX_CODE === 2'h1) begin
        exp_seq = TX_SEQ;
        chk_bit(TX_ACK_OK, 1'b0);
      end
      chk_val(TX_SEQ, exp_seq);
      if (TX_CODE !== 2'h0 || TX_HAS_DATA === 1'b1) exp_seq = nxt(exp_seq);
      if (TX_HAS_DATA === 1'b1) chk_val(10'(TX_DATA), 10'(sent_q.pop_front()));
    end
    if (RECV_VALID === 1'b1) begin
      chk_val(10'(RECV_DATA), 10'(rcnt ^ 8'h5a));
      rcnt++;
    end
  end
  // ==================================================================
  // main sequence: open, long run across the 999 wrap, local close, reopen, declined peer close
  initial begin
    repeat (10) @(posedge REF_CLK);
    chk_bit(TX_VALID | LINK_OPEN | SEND_READY, 1'b0);
    RST_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    OPEN_REQ <= 1'b1;
    @(posedge REF_CLK);
    OPEN_REQ <= 1'b0;
    wait_link(1'b1);
    for (int i = 0; i < 1010; i++) send_word(8'($random(seed)));
    {SEND_VALID, CLOSE_REQ} <= 2'b01;
    wait_link(1'b0);
    CLOSE_REQ <= 1'b0;
    settle();
    chk_bit(acked_all, 1'b1);
    OPEN_REQ <= 1'b1;
    @(posedge REF_CLK);
    OPEN_REQ <= 1'b0;
    wait_link(1'b1);
    close_cmd <= 1'b1;
    @(posedge REF_CLK);
    close_cmd <= 1'b0;
    send_word(8'ha5);
    SEND_VALID <= 1'b0;
    wait_link(1'b0);
    settle();
    chk_val(10'(sent_q.size()), 10'h000);
    chk_bit(acked_all, 1'b1);
    close_out();
  end
endmodule : control_transport_session_tb_top
